// File: psa_pkg.sv
// shared constants and types of the phy status and advertisement register group
package psa_pkg;
    // management register addresses
    localparam logic [4:0]  REG_STATUS    = 5'h01;
    localparam logic [4:0]  REG_ID_LOW    = 5'h02;
    localparam logic [4:0]  REG_ID_HIGH   = 5'h03;
    localparam logic [4:0]  REG_ADV       = 5'h04;
    localparam logic [4:0]  REG_PARTNER   = 5'h05;
    // basic status bit positions
    localparam int          BS_T4         = 15;
    localparam int          BS_FTX_FULL   = 14;
    localparam int          BS_FTX_HALF   = 13;
    localparam int          BS_TEN_FULL   = 12;
    localparam int          BS_TEN_HALF   = 11;
    localparam int          BS_EXT_STAT   = 8;
    localparam int          BS_TX_ANY     = 7;
    localparam int          BS_PRE_SKIP   = 6;
    localparam int          BS_NEG_DONE   = 5;
    localparam int          BS_RFAULT     = 4;
    localparam int          BS_NEG_CAP    = 3;
    localparam int          BS_LINK       = 2;
    localparam int          BS_JABBER     = 1;
    localparam int          BS_EXT_CAP    = 0;
    // identifier layout
    localparam int          ID_HIGH_LSB   = 10;
    localparam int          MODEL_LSB     = 4;
    // advertisement layout
    localparam int          ADV_RSVD      = 14;
    localparam int          ADV_T4        = 9;
    localparam logic [15:0] ADV_RESET     = 16'h1DE1;
    localparam logic [15:0] ADV_WR_MASK   = 16'hBDE0;
    localparam logic [15:0] ADV_DEFER     = 16'h8DE0;
    localparam logic [15:0] ADV_SELECTOR  = 16'h0001;
    localparam logic [15:0] ZERO16        = 16'h0000;
    // serial management framing
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [5:0]  PRE_BITS      = 6'h20;
    localparam logic [3:0]  HDR_LAST      = 4'hC;
    localparam logic [3:0]  TA_LAST       = 4'h1;
    localparam logic [3:0]  DATA_LAST     = 4'hF;

    typedef enum logic [1:0] {MS_IDLE, MS_HDR, MS_TA, MS_DATA} psa_mdio_state_e;
endpackage : psa_pkg

// File: psa_mgmt_if.sv
// register request and answer path between frame engine and register bank
`timescale 1ns/1ps
interface psa_mgmt_if;
    logic        rd_req;
    logic        wr_req;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    modport engine (output rd_req, output wr_req, output reg_addr, output wr_data,
                    input rd_data);
    modport bank   (input rd_req, input wr_req, input reg_addr, input wr_data,
                    output rd_data);
endinterface : psa_mgmt_if

// File: psa_mdio_engine.sv
// serial management frame engine: samples mdc/mdio, decodes frames, drives read data
`timescale 1ns/1ps
module psa_mdio_engine
    import psa_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic [4:0] phy_addr,
    psa_mgmt_if.engine      mg
);
    logic            mdc_s1_ff, mdc_s2_ff, mdc_d_ff;
    logic            mdio_s1_ff, mdio_s2_ff;
    logic            mdc_rise;
    psa_mdio_state_e state_ff;
    logic [5:0]      ones_ff;
    logic            pre_seen_ff;
    logic [3:0]      cnt_ff;
    logic [11:0]     hdr_ff;
    logic [12:0]     hdr_nxt;
    logic            rd_go_ff, wr_go_ff;
    logic [15:0]     sh_ff;
    logic            rd_req_ff, wr_req_ff;
    logic [4:0]      addr_ff;
    logic [15:0]     wdata_ff;

    // two-flop synchronisers; edge detect looks only at the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mdc_s1_ff  <= 1'b0;
            mdc_s2_ff  <= 1'b0;
            mdc_d_ff   <= 1'b0;
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
        end else begin
            mdc_s1_ff  <= mdc;
            mdc_s2_ff  <= mdc_s1_ff;
            mdc_d_ff   <= mdc_s2_ff;
            mdio_s1_ff <= mdio_in;
            mdio_s2_ff <= mdio_s1_ff;
        end
    end

    assign mdc_rise = mdc_s2_ff & ~mdc_d_ff;
    assign hdr_nxt  = {hdr_ff, mdio_s2_ff};

    // frame sequencing; a start needs a preceding idle one, full preamble only once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff    <= MS_IDLE;
            ones_ff     <= 6'h00;
            pre_seen_ff <= 1'b0;
            cnt_ff      <= 4'h0;
            hdr_ff      <= 12'h000;
            rd_go_ff    <= 1'b0;
            wr_go_ff    <= 1'b0;
        end else if (mdc_rise) begin
            case (state_ff)
                MS_IDLE: begin
                    if (mdio_s2_ff) begin
                        if (ones_ff != PRE_BITS) ones_ff <= ones_ff + 6'h01;
                    end else begin
                        if (ones_ff != 6'h00 && (pre_seen_ff || ones_ff == PRE_BITS)) begin
                            state_ff    <= MS_HDR;
                            pre_seen_ff <= 1'b1;
                        end
                        ones_ff <= 6'h00;
                    end
                    cnt_ff <= 4'h0;
                end
                MS_HDR: begin
                    hdr_ff <= hdr_nxt[11:0];
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        rd_go_ff <= hdr_nxt[12] && hdr_nxt[11:10] == OP_READ
                                    && hdr_nxt[9:5] == phy_addr;
                        wr_go_ff <= hdr_nxt[12] && hdr_nxt[11:10] == OP_WRITE
                                    && hdr_nxt[9:5] == phy_addr;
                        state_ff <= MS_TA;
                        cnt_ff   <= 4'h0;
                    end
                end
                MS_TA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == TA_LAST) begin
                        state_ff <= MS_DATA;
                        cnt_ff   <= 4'h0;
                    end
                end
                MS_DATA: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == DATA_LAST) begin
                        state_ff <= MS_IDLE;
                        rd_go_ff <= 1'b0;
                        wr_go_ff <= 1'b0;
                    end
                end
                default: state_ff <= MS_IDLE;
            endcase
        end
    end

    // pin drive: released in first turnaround bit, zero in second, then data msb first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b1;
            sh_ff    <= 16'h0000;
        end else if (mdc_rise) begin
            if (state_ff == MS_TA && cnt_ff == 4'h0 && rd_go_ff) begin
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
            end else if (state_ff == MS_TA && cnt_ff == TA_LAST) begin
                mdio_out <= mg.rd_data[15];
                sh_ff    <= {mg.rd_data[14:0], 1'b0};
            end else if (state_ff == MS_DATA) begin
                mdio_out <= rd_go_ff ? sh_ff[15] : 1'b1;
                sh_ff    <= {sh_ff[14:0], mdio_s2_ff};
                if (cnt_ff == DATA_LAST) mdio_oe <= 1'b0;
            end
        end
    end

    // one-cycle register requests toward the bank
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_req_ff <= 1'b0;
            wr_req_ff <= 1'b0;
            addr_ff   <= 5'h00;
            wdata_ff  <= 16'h0000;
        end else begin
            rd_req_ff <= mdc_rise && state_ff == MS_HDR && cnt_ff == HDR_LAST
                         && hdr_nxt[12] && hdr_nxt[11:10] == OP_READ
                         && hdr_nxt[9:5] == phy_addr;
            wr_req_ff <= mdc_rise && state_ff == MS_DATA && cnt_ff == DATA_LAST && wr_go_ff;
            if (mdc_rise && state_ff == MS_HDR && cnt_ff == HDR_LAST) addr_ff <= hdr_nxt[4:0];
            if (mdc_rise && state_ff == MS_DATA && cnt_ff == DATA_LAST)
                wdata_ff <= {sh_ff[14:0], mdio_s2_ff};
        end
    end

    assign mg.rd_req   = rd_req_ff;
    assign mg.wr_req   = wr_req_ff;
    assign mg.reg_addr = addr_ff;
    assign mg.wr_data  = wdata_ff;
endmodule : psa_mdio_engine

// File: psa_status_regs.sv
// status, identifier, advertisement and partner ability registers behind serial management
// Behaviour
// - status bits 15 to 11 are fixed: T4 zero, four speed/duplex capabilities one
// - status bit 8 reads one: extended status register exists
// - status bit 7 reads zero; transmit accepted only with valid link
// - status bit 6 reads one; frames without preamble accepted after the first full preamble
// - status bit 5 shows negotiation complete, resets to zero
// - status bit 4 sets on remote fault, clears on read or reset
// - status bit 3 reads one: negotiation capable
// - status bit 2 latches link loss until read; read twice for present state
// - status bit 1 shows jabber, resets to zero
// - status bit 0 reads one: extended registers via address/data pair
// - identifier low returns id bits 18..3, high bits 15..10 return 24..19
// - identifier high holds model in 9..4 and revision in 3..0
// - advertisement forms base page; selector reads 00001
// - advertisement bits 15 and 13 writable, reset zero; bit 14 zero
// - advertisement bit 12 writable, resets one
// - advertisement pause bits 11 and 10 writable, reset one
// - advertisement bits 8..5 writable, reset one; bit 9 reads zero
// - deferred bits apply on soft reset, restart, power-up or link loss
// - partner ability captures received base page
// - soft reset returns status register to defaults
// - negotiation restart pulse is taken as an apply event
`timescale 1ns/1ps
module psa_status_regs
    import psa_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR     = 5'h01,
    parameter logic [15:0] ID_BITS_LOW  = 16'h1234, // arbitrary value
    parameter logic [5:0]  ID_BITS_HIGH = 6'h15,    // arbitrary value
    parameter logic [5:0]  MODEL_NUM    = 6'h2A,    // arbitrary value
    parameter logic [3:0]  REV_NUM      = 4'h3      // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic        soft_reset_pulse,
    input  wire logic        negotiation_restart,
    input  wire logic        power_down_ctl,
    input  wire logic        link_up,
    input  wire logic        negotiation_done_flag,
    input  wire logic        remote_fault_evt,
    input  wire logic        jabber_det,
    input  wire logic        partner_valid,
    input  wire logic [15:0] partner_word,
    output logic [15:0]      base_page_word,
    output logic             adv_apply,
    output logic             tx_accept
);
    psa_mgmt_if mg ();

    logic        neg_done_ff, rfault_ff, link_lat_ff, jabber_ff;
    logic        pwd_d_ff, link_d_ff;
    logic [15:0] adv_ff, adv_eff_ff, partner_ff, rd_data_ff;
    logic [15:0] status_w, rd_mux;
    logic        status_rd, adv_wr, apply_evt;
    logic        tx_ok_ff;

    psa_mdio_engine u_engine (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .phy_addr (PHY_ADDR),
        .mg       (mg.engine)
    );

    assign status_rd = mg.rd_req && mg.reg_addr == REG_STATUS;
    assign adv_wr    = mg.wr_req && mg.reg_addr == REG_ADV;

    // live status flags; soft reset returns them to defaults
    always_ff @(posedge core_clk) begin
        if (!rst_n || soft_reset_pulse) begin
            neg_done_ff <= 1'b0;
            jabber_ff   <= 1'b0;
        end else begin
            neg_done_ff <= negotiation_done_flag;
            jabber_ff   <= jabber_det;
        end
    end

    // sticky remote fault: a fault in the read cycle survives the clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rfault_ff <= 1'b0;
        end else if (remote_fault_evt) begin
            rfault_ff <= 1'b1;
        end else if (status_rd || soft_reset_pulse) begin
            rfault_ff <= 1'b0;
        end
    end

    // link latched low; a read reloads the present state so a drop is never missed
    always_ff @(posedge core_clk) begin
        if (!rst_n || soft_reset_pulse) begin
            link_lat_ff <= 1'b0;
        end else if (status_rd) begin
            link_lat_ff <= link_up;
        end else if (!link_up) begin
            link_lat_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) tx_ok_ff <= 1'b0;
        else        tx_ok_ff <= link_up;
    end
    assign tx_accept = tx_ok_ff;

    // basic status word assembly
    always_comb begin
        status_w              = ZERO16;
        status_w[BS_T4]       = 1'b0;
        status_w[BS_FTX_FULL] = 1'b1;
        status_w[BS_FTX_HALF] = 1'b1;
        status_w[BS_TEN_FULL] = 1'b1;
        status_w[BS_TEN_HALF] = 1'b1;
        status_w[BS_EXT_STAT] = 1'b1;
        status_w[BS_TX_ANY]   = 1'b0;
        status_w[BS_PRE_SKIP] = 1'b1;
        status_w[BS_NEG_DONE] = neg_done_ff;
        status_w[BS_RFAULT]   = rfault_ff;
        status_w[BS_NEG_CAP]  = 1'b1;
        status_w[BS_LINK]     = link_lat_ff;
        status_w[BS_JABBER]   = jabber_ff;
        status_w[BS_EXT_CAP]  = 1'b1;
    end

    // stored advertisement; only writable bits take the write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            adv_ff <= ADV_RESET & ADV_WR_MASK;
        end else if (adv_wr) begin
            adv_ff <= mg.wr_data & ADV_WR_MASK;
        end
    end

    // edge detection of apply conditions; inputs share this clock
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pwd_d_ff  <= 1'b0;
            link_d_ff <= 1'b0;
        end else begin
            pwd_d_ff  <= power_down_ctl;
            link_d_ff <= link_up;
        end
    end

    assign apply_evt = soft_reset_pulse || negotiation_restart
                       || (pwd_d_ff && !power_down_ctl) || (link_d_ff && !link_up);

    // deferred copy of the starred bits; stale until an apply event
    always_ff @(posedge core_clk) begin
        if (!rst_n) adv_eff_ff <= ADV_RESET & ADV_DEFER;
        else if (apply_evt) adv_eff_ff <= adv_ff & ADV_DEFER;
    end

    assign base_page_word = adv_eff_ff | (adv_ff & ADV_WR_MASK & ~ADV_DEFER) | ADV_SELECTOR;
    assign adv_apply      = apply_evt;

    always_ff @(posedge core_clk) begin
        if (!rst_n) partner_ff <= ZERO16;
        else if (partner_valid) partner_ff <= partner_word;
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        case (mg.reg_addr)
            REG_STATUS:  rd_mux = status_w;
            REG_ID_LOW:  rd_mux = ID_BITS_LOW;
            REG_ID_HIGH: rd_mux = {ID_BITS_HIGH, MODEL_NUM, REV_NUM};
            REG_ADV:     rd_mux = (adv_ff & ADV_WR_MASK) | ADV_SELECTOR;
            REG_PARTNER: rd_mux = partner_ff;
            default:     rd_mux = ZERO16;
        endcase
    end

    // read data held for the turnaround; engine shifts it out later
    always_ff @(posedge core_clk) begin
        if (!rst_n) rd_data_ff <= ZERO16;
        else if (mg.rd_req) rd_data_ff <= rd_mux;
    end
    assign mg.rd_data = rd_data_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_adv_write;
        adv_wr && !apply_evt;
    endsequence
    sequence s_no_apply;
        !apply_evt [*3];
    endsequence

    caps_fixed_a: assert property (status_rd |=> mg.rd_data[15:11] == 5'b01111)
        else $error("capability bits wrong");
    ext_status_a: assert property (status_rd |=> mg.rd_data[BS_EXT_STAT])
        else $error("extended status bit not set");
    tx_link_a: assert property (status_rd |=> !mg.rd_data[BS_TX_ANY] && tx_accept == $past(link_up))
        else $error("transmit gating wrong");
    pre_skip_a: assert property (status_rd |=> mg.rd_data[BS_PRE_SKIP] && mg.rd_data[BS_NEG_CAP])
        else $error("preamble skip or ability bit wrong");
    neg_done_a: assert property (status_rd && !soft_reset_pulse |=> mg.rd_data[BS_NEG_DONE] == $past(neg_done_ff))
        else $error("negotiation done not reported");
    rfault_set_a: assert property (remote_fault_evt ##1 status_rd |=> mg.rd_data[BS_RFAULT])
        else $error("remote fault lost");
    rfault_clr_a: assert property (status_rd && !remote_fault_evt |=> !rfault_ff)
        else $error("remote fault not cleared on read");
    link_latch_a: assert property (!link_up && !status_rd && !soft_reset_pulse ##1 !mg.rd_req [*2] |=> mg.rd_data == $past(mg.rd_data) && !link_lat_ff)
        else $error("link loss not latched");
    jabber_a: assert property (jabber_det && !soft_reset_pulse |=> jabber_ff)
        else $error("jabber not shown");
    ext_cap_a: assert property (status_rd |=> mg.rd_data[BS_EXT_CAP])
        else $error("extended capability bit clear");
    id_high_a: assert property (mg.rd_req && mg.reg_addr == REG_ID_HIGH |=> mg.rd_data == {ID_BITS_HIGH, MODEL_NUM, REV_NUM})
        else $error("identifier high wrong");
    selector_a: assert property (base_page_word[4:0] == ADV_SELECTOR[4:0] && !base_page_word[ADV_T4])
        else $error("selector field wrong");
    adv_ro_a: assert property (mg.rd_req && mg.reg_addr == REG_ADV |=> !mg.rd_data[ADV_RSVD] && !mg.rd_data[ADV_T4])
        else $error("read-only advertisement bit set");
    adv_defer_a: assert property (s_adv_write ##1 s_no_apply |-> $stable(base_page_word & ADV_DEFER))
        else $error("deferred bits changed without apply");
    adv_apply_a: assert property (apply_evt && !adv_wr |=> (base_page_word & ADV_DEFER) == (adv_ff & ADV_DEFER))
        else $error("advertisement not applied");
    partner_cap_a: assert property (partner_valid |=> partner_ff == $past(partner_word))
        else $error("partner word not captured");
    soft_rst_a: assert property (soft_reset_pulse && !remote_fault_evt |=> !rfault_ff && !link_lat_ff)
        else $error("soft reset did not restore status");
endmodule : psa_status_regs

// File: psa_mdio_host.sv
// station management controller model driving the serial management pins
`timescale 1ns/1ps
module psa_mdio_host
    import psa_pkg::*;
(
    output logic      mdc,
    output logic      host_out,
    output logic      host_oe,
    input  wire logic mdio_wire
);
    logic sample;

    // mdc stands low between frames, the line is left to the pull-up
    initial begin
        mdc = 1'b0;
        host_out = 1'b1;
        host_oe = 1'b0;
    end

    // one 64 ns bit; mdc edges kept off the core clock edges on purpose
    task automatic bit_cyc(input logic v);
        #1;
        host_out = v;
        #16;
        sample = mdio_wire;
        mdc = 1'b1;
        #32;
        mdc = 1'b0;
        #15;
    endtask : bit_cyc

    // whole frame, phy address 5'h01 as the bench straps it
    task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                        input int pre, output logic [15:0] rd);
        logic [13:0] hdr;
        hdr = {2'b01, (wr ? OP_WRITE : OP_READ), 5'h01, ra};
        rd = ZERO16;
        host_oe = 1'b1;
        repeat (pre) bit_cyc(1'b1);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i]);
        if (wr) begin
            bit_cyc(1'b1);
            bit_cyc(1'b0);
            for (int i = 15; i >= 0; i--) bit_cyc(wd[i]);
        end else begin
            // released turnaround, device owns the line for data
            host_oe = 1'b0;
            repeat (2) bit_cyc(1'b1);
            for (int i = 15; i >= 0; i--) begin
                bit_cyc(1'b1);
                rd[i] = sample;
            end
            host_oe = 1'b1;
        end
        bit_cyc(1'b1);
        host_oe = 1'b0;
    endtask : xfer
endmodule : psa_mdio_host

// File: psa_status_regs_tb.sv
// self-checking bench of the status and advertisement register group
`timescale 1ns/1ps
module psa_status_regs_tb;
    import psa_pkg::*;
    localparam logic [15:0] T_ID_LOW = 16'h5A3C; // arbitrary value
    localparam logic [5:0]  T_ID_HI  = 6'h2D;    // arbitrary value
    localparam logic [5:0]  T_MODEL  = 6'h17;    // arbitrary value
    localparam logic [3:0]  T_REV    = 4'h6;     // arbitrary value
    logic        core_clk, rst_n, mdc, host_out, host_oe, mdio_out, mdio_oe, mdio_wire;
    logic        sr_p, rs_p, pd, link_up, nd, rf, jb, pv, adv_apply, tx_accept;
    logic [15:0] pw, base_page_word, rd, stored, applied, w;
    logic [3:0]  r;
    int          n_errors, checks_done, cyc;

    // pull-up wins whenever nobody drives the data line
    assign mdio_wire = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);

    psa_status_regs #(.ID_BITS_LOW(T_ID_LOW), .ID_BITS_HIGH(T_ID_HI), .MODEL_NUM(T_MODEL),
                      .REV_NUM(T_REV)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .soft_reset_pulse(sr_p),
        .negotiation_restart(rs_p), .power_down_ctl(pd), .link_up(link_up),
        .negotiation_done_flag(nd), .remote_fault_evt(rf), .jabber_det(jb),
        .partner_valid(pv), .partner_word(pw), .base_page_word(base_page_word),
        .adv_apply(adv_apply), .tx_accept(tx_accept));

    psa_mdio_host host (.mdc(mdc), .host_out(host_out), .host_oe(host_oe),
                        .mdio_wire(mdio_wire));

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // frames after the first skip the preamble
    task automatic rd_reg(input logic [4:0] a);
        host.xfer(1'b0, a, ZERO16, 0, rd);
    endtask : rd_reg

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        host.xfer(1'b1, a, d, 0, dummy);
    endtask : wr_reg

    // one-cycle apply event: soft reset, restart, power-down exit, link drop
    task automatic fire(input int k);
        @(posedge core_clk);
        case (k)
            0: sr_p <= 1'b1;
            1: rs_p <= 1'b1;
            2: pd <= 1'b1;
            default: link_up <= 1'b0;
        endcase
        #1;
        check("apply", {15'h0000, adv_apply}, {15'h0000, k != 2});
        tick(1);
        {sr_p, rs_p, pd, link_up} <= 4'b0001;
        #1;
        check("apply", {15'h0000, adv_apply}, {15'h0000, k == 2});
        tick(3);
    endtask : fire

    function automatic logic [15:0] exp_status(logic d, logic f, logic l, logic j);
        return {5'b01111, 2'b00, 1'b1, 1'b0, 1'b1, d, f, 1'b1, l, j, 1'b1};
    endfunction : exp_status

    // deferred bits from the applied copy, bits 13 and 12 straight from storage
    function automatic logic [15:0] exp_base();
        return (applied & ADV_DEFER) | (stored & 16'h3000) | ADV_SELECTOR;
    endfunction : exp_base

    // hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        {rst_n, sr_p, rs_p, pd, nd, rf, jb, pv} = 8'h00;
        link_up = 1'b1;
        pw = ZERO16;
        cyc = 0;
        n_errors = 0;
        checks_done = 0;
        stored = ADV_RESET;
        applied = ADV_RESET;
        void'($urandom(32'h16D7));
        tick(2);
        rst_n <= 1'b1;
        tick(4);
        check("base", base_page_word, 16'h1DE1);
        host.xfer(1'b0, REG_ADV, ZERO16, 32, rd);
        check("adv", rd, 16'h1DE1);
        rd_reg(REG_ID_LOW);
        check("id_low", rd, T_ID_LOW);
        wr_reg(REG_ID_LOW, 16'hFFFF);
        rd_reg(REG_ID_HIGH);
        check("id_high", rd, {T_ID_HI, T_MODEL, T_REV});
        rd_reg(REG_ID_LOW);
        check("id_low", rd, T_ID_LOW);
        rd_reg(5'h06);
        check("unmapped", rd, ZERO16);
        check("tx", {15'h0000, tx_accept}, 16'h0001);
        rf <= 1'b1;
        tick(1);
        rf <= 1'b0;
        // stored advertisement at once, deferred bits effective only after each event
        for (int k = 0; k < 4; k++) begin
            w = (k == 0) ? 16'hFFFF : ((k == 1) ? ZERO16 : 16'($urandom));
            wr_reg(REG_ADV, w);
            stored = (w & ADV_WR_MASK) | ADV_SELECTOR;
            rd_reg(REG_ADV);
            check("adv", rd, stored);
            check("base", base_page_word, exp_base());
            fire(k);
            applied = stored;
            check("base", base_page_word, exp_base());
        end
        wr_reg(REG_STATUS, ZERO16);
        rd_reg(REG_STATUS);
        check("status", rd, exp_status(1'b0, 1'b0, 1'b0, 1'b0));
        // all status events first, then random ones, each read twice
        for (int i = 0; i < 5; i++) begin
            r = (i == 0) ? 4'hF : 4'($urandom);
            @(posedge core_clk);
            nd <= r[0];
            jb <= r[1];
            rf <= r[2];
            link_up <= ~r[3];
            @(posedge core_clk);
            rf <= 1'b0;
            link_up <= 1'b1;
            if (r[3]) applied = stored;
            rd_reg(REG_STATUS);
            check("status", rd, exp_status(r[0], r[2], ~r[3], r[1]));
            rd_reg(REG_STATUS);
            check("status", rd, exp_status(r[0], 1'b0, 1'b1, r[1]));
        end
        w = 16'($urandom);
        @(posedge core_clk);
        pw <= w;
        pv <= 1'b1;
        @(posedge core_clk);
        pv <= 1'b0;
        rd_reg(REG_PARTNER);
        check("partner", rd, w);
        check("base", base_page_word, exp_base());
        wrap_up();
    end
endmodule : psa_status_regs_tb
